// ---- shared/fdc_pkg.sv ----
// package for the flash driver mode controller and adaptive output loop
// assumes one 10 MHz clock and a plain address/strobe register port
package fdc_pkg;

  localparam int CLK_PERIOD_NS   = 100;
  localparam int STEP_SS_NS      = 1000;   // 1 us step during soft-start
  localparam int STEP_NORM_NS    = 8000;   // 8 us step in normal operation
  localparam int STEP_SS_CYC     = (STEP_SS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STEP_NORM_CYC   = (STEP_NORM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OVP_DEB_US      = 100;    // debounce time, plain default
  localparam int OVP_DEB_CYC     = OVP_DEB_US * 1000 / CLK_PERIOD_NS;

  localparam int DAC_W           = 9;
  localparam logic [8:0] DAC_RESET     = 9'h000;
  localparam logic [8:0] OVP_LIM_RESET = 9'h1ff;

  // duty cycle in 1/32 units: 3.125 % .. 75 %
  localparam logic [5:0] DUTY_MIN = 6'h01;
  localparam logic [5:0] DUTY_MAX = 6'h18;

  // headroom target in mV = base + step * code
  localparam int HEADROOM_BASE_MV = 120;
  localparam int HEADROOM_STEP_MV = 30;

  // boost mode select codes
  localparam logic [1:0] MODE_LP_ADAPT  = 2'h0;
  localparam logic [1:0] MODE_PREBIAS   = 2'h1;
  localparam logic [1:0] MODE_FIXED     = 2'h2;
  localparam logic [1:0] MODE_DROPOUT   = 2'h3;

  // register byte addresses
  localparam logic [7:0] ADDR_CTRL      = 8'h00;
  localparam logic [7:0] ADDR_OVP_LIM   = 8'h04;
  localparam logic [7:0] ADDR_STATUS    = 8'h08;
  localparam logic [7:0] ADDR_LAST_OUT  = 8'h0c;
  localparam logic [7:0] ADDR_PEAK_OUT  = 8'h10;
  localparam logic [7:0] ADDR_DAC       = 8'h14;

  // control register field positions
  localparam int CTRL_MODE_LO   = 0;
  localparam int CTRL_TORCH_LO  = 2;
  localparam int CTRL_FLASH_LO  = 4;
  localparam int CTRL_TPIN_BIT  = 6;
  localparam int CTRL_SPIN_BIT  = 7;
  localparam int CTRL_SKIP_BIT  = 8;
  localparam int CTRL_HR_LO     = 9;
  localparam int CTRL_W         = 11;
  localparam logic [10:0] CTRL_RESET = 11'h000;
  localparam int STAT_FAULT_BIT = 3;

  typedef enum logic [2:0] {
    ST_SHUTDOWN, ST_STANDBY, ST_ACTIVE, ST_TORCH, ST_FLASH
  } fdc_state_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } fdc_bus_req_t;

  typedef struct packed {
    logic supply_ok;   // logic supply above logic_supply_undervolt_level
    logic main_ok;     // main input above main_input_undervolt_level
    logic torch_pin;
    logic strobe_trigger;
    logic hr_low;      // regulator headroom below target
    logic hr_high;     // regulator headroom above target
    logic min_duty;    // converter at minimum duty
    logic ilim;        // converter at peak input current limit
    logic vout_high;   // output high enough to skip a cycle
    logic soft_start;  // converter ramping
  } fdc_pins_t;

endpackage : fdc_pkg

// ---- hw/fdc_sync.sv ----
// three-stage synchroniser with agreement filter for asynchronous pins
// assumes pins are static for at least three clock periods around a change
module fdc_sync #(
  parameter int W = 1
) (
  input  wire logic         ref_clk,  // system clock
  input  wire logic         rstn,     // async reset, active low
  input  wire logic [W-1:0] d,        // asynchronous inputs
  output      logic [W-1:0] q         // filtered, synchronous copy
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] q_next;

  // a bit changes only once stages two and three agree
  assign q_next = (s2_reg & s3_reg) | (q & (s2_reg | s3_reg));

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      q      <= '0;
    end else begin
      s1_reg <= d;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      q      <= q_next;
    end
  end
endmodule : fdc_sync

// ---- hw/fdc_ctrl.sv ----
// flash driver mode controller with adaptive output voltage loop
// assumes analog comparators on the pin inputs and a same-clock duty request
module fdc_ctrl
  import fdc_pkg::*;
#(
  parameter int                 DEB_CYC  = OVP_DEB_CYC,  // overvoltage debounce in cycles
  parameter logic [DAC_W-1:0]   DAC_INIT = DAC_RESET     // DAC code after reset
) (
  input  wire logic         ref_clk,       // 10 MHz clock
  input  wire logic         rstn,          // async reset, active low
  input  wire fdc_bus_req_t bus_req,       // register port request
  output      logic [31:0]  rdata,         // read data, cycle after read
  input  wire fdc_pins_t    pins,          // asynchronous pin and comparator inputs
  input  wire logic [5:0]   duty_req,      // duty request from modulator, 1/32 units
  output      logic         boost_en,      // converter enable
  output      logic [1:0]   boost_mode,    // boost_mode_select to converter
  output      logic [1:0]   reg_en,        // current regulator enables
  output      logic [1:0]   reg_flash,     // regulator uses flash settings
  output      logic [8:0]   dac_code,      // output voltage DAC code
  output      logic [1:0]   headroom_sel,  // headroom target code
  output      logic         skip_cycle,    // omit next switching cycle
  output      logic [5:0]   duty_cmd,      // clamped duty command
  output      logic         ovp_fault      // debounce expired, outputs disabled
);
  fdc_pins_t  ps;
  fdc_state_t state_reg;
  fdc_state_t state_next;

  logic [CTRL_W-1:0] ctrl_reg;
  logic [CTRL_W-1:0] ctrl_next;
  logic [8:0]        ovp_lim_reg;
  logic [8:0]        last_reg;
  logic [8:0]        peak_reg;
  logic [6:0]        tick_cnt_reg;
  logic [15:0]       deb_cnt_reg;
  logic [31:0]       rdata_next;

  fdc_sync #(.W($bits(fdc_pins_t))) u_sync (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .d       (pins),
    .q       (ps)
  );

  // register field decode
  wire [1:0] mode_f     = ctrl_reg[CTRL_MODE_LO +: 2];
  wire [1:0] torch_f    = ctrl_reg[CTRL_TORCH_LO +: 2];
  wire [1:0] flash_f    = ctrl_reg[CTRL_FLASH_LO +: 2];
  wire       tpin_en    = ctrl_reg[CTRL_TPIN_BIT];
  wire       spin_en    = ctrl_reg[CTRL_SPIN_BIT];
  wire       skip_en    = ctrl_reg[CTRL_SKIP_BIT];

  wire live      = ps.supply_ok;
  wire wr_ok     = bus_req.wr && live;
  wire rd_ok     = bus_req.rd && live;
  wire wr_ctrl   = wr_ok && (bus_req.addr == ADDR_CTRL);
  wire wr_ovp    = wr_ok && (bus_req.addr == ADDR_OVP_LIM);
  wire wr_stat   = wr_ok && (bus_req.addr == ADDR_STATUS);

  // triggers gate the enables only when the pin option is set
  wire [1:0] torch_on = torch_f & {2{~tpin_en | ps.torch_pin}};
  wire [1:0] flash_on = flash_f & {2{~spin_en | ps.strobe_trigger}};
  wire       any_torch = |torch_on;
  wire       any_flash = |flash_on;
  wire       any_reg   = any_torch | any_flash;
  wire       sw_boost  = (mode_f != MODE_LP_ADAPT);
  wire       go_down   = !ps.main_ok || ovp_fault;

  wire in_event   = (state_reg == ST_TORCH) || (state_reg == ST_FLASH);
  wire next_event = (state_next == ST_TORCH) || (state_next == ST_FLASH);
  wire next_on    = next_event || (state_next == ST_ACTIVE);

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_SHUTDOWN: if (live) state_next = ST_STANDBY;
      ST_STANDBY: begin
        if (ps.main_ok && !ovp_fault && (any_reg || sw_boost)) state_next = ST_ACTIVE;
      end
      ST_ACTIVE: begin
        if (go_down || (!sw_boost && !any_reg)) state_next = ST_STANDBY;
        else if (any_flash) state_next = ST_FLASH;
        else if (any_torch) state_next = ST_TORCH;
      end
      ST_TORCH: begin
        if (go_down) state_next = ST_STANDBY;
        else if (any_flash) state_next = ST_FLASH;
        else if (!any_torch) state_next = ST_ACTIVE;
      end
      ST_FLASH: begin
        if (go_down) state_next = ST_STANDBY;
        else if (!any_flash) state_next = any_torch ? ST_TORCH : ST_ACTIVE;
      end
    endcase
    if (!live) state_next = ST_SHUTDOWN;
  end

  // adaptive loop step timing and direction
  wire [6:0] step_len  = ps.soft_start ? 7'(STEP_SS_CYC) : 7'(STEP_NORM_CYC);
  wire       tick      = in_event && (tick_cnt_reg >= step_len - 7'h01);
  wire       want_up   = ps.hr_low;
  wire       want_down = ps.hr_high && !ps.hr_low;
  wire       at_lim    = (dac_code >= ovp_lim_reg);
  wire       ovp_req   = in_event && want_up && at_lim;
  wire       step_up   = tick && want_up && !ps.ilim && !at_lim;
  wire       step_down = tick && want_down && !ps.min_duty && (dac_code != '0);
  wire [8:0] dac_next  = step_up   ? 9'(dac_code + 9'h001) :
                         step_down ? 9'(dac_code - 9'h001) : dac_code;
  wire       deb_done  = (deb_cnt_reg >= 16'(DEB_CYC));
  wire       fault_set = ovp_req && deb_done;

  wire [5:0] duty_next = (duty_req < DUTY_MIN) ? DUTY_MIN :
                         (duty_req > DUTY_MAX) ? DUTY_MAX : duty_req;

  // outputs built from ctrl_next must not lag the register reset by a cycle
  assign ctrl_next = !live ? CTRL_RESET : wr_ctrl ? bus_req.wdata[CTRL_W-1:0] : ctrl_reg;

  always_comb begin
    rdata_next = '0;
    if (rd_ok) begin
      unique case (bus_req.addr)
        ADDR_CTRL:     rdata_next = 32'(ctrl_reg);
        ADDR_OVP_LIM:  rdata_next = 32'(ovp_lim_reg);
        ADDR_STATUS:   rdata_next = 32'({ovp_fault, state_reg});
        ADDR_LAST_OUT: rdata_next = 32'(last_reg);
        ADDR_PEAK_OUT: rdata_next = 32'(peak_reg);
        ADDR_DAC:      rdata_next = 32'(dac_code);
        default:       rdata_next = '0;
      endcase
    end
  end

  // software registers: held at reset while the logic supply is low
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_reg    <= CTRL_RESET;
      ovp_lim_reg <= OVP_LIM_RESET;
      ovp_fault   <= 1'b0;
    end else if (!live) begin
      ctrl_reg    <= CTRL_RESET;
      ovp_lim_reg <= OVP_LIM_RESET;
      ovp_fault   <= 1'b0;
    end else begin
      ctrl_reg    <= ctrl_next;
      ovp_lim_reg <= wr_ovp ? bus_req.wdata[8:0] : ovp_lim_reg;
      // a new fault wins over a simultaneous software clear
      ovp_fault   <= fault_set || (ovp_fault && !(wr_stat && bus_req.wdata[STAT_FAULT_BIT]));
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg    <= ST_SHUTDOWN;
      rdata        <= '0;
      boost_en     <= 1'b0;
      boost_mode   <= MODE_LP_ADAPT;
      reg_en       <= 2'h0;
      reg_flash    <= 2'h0;
      headroom_sel <= 2'h0;
      skip_cycle   <= 1'b0;
      duty_cmd     <= DUTY_MIN;
    end else begin
      state_reg    <= state_next;
      rdata        <= rdata_next;
      boost_en     <= next_on;
      boost_mode   <= ctrl_next[CTRL_MODE_LO +: 2];
      reg_en       <= next_event ? (torch_on | flash_on) : 2'h0;
      reg_flash    <= (state_next == ST_FLASH) ? flash_on : 2'h0;
      headroom_sel <= ctrl_next[CTRL_HR_LO +: 2];
      skip_cycle   <= next_on && ctrl_next[CTRL_SKIP_BIT] && ps.vout_high;
      duty_cmd     <= duty_next;
    end
  end

  // loop timing, DAC code and output logs
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      tick_cnt_reg <= '0;
      deb_cnt_reg  <= '0;
      dac_code     <= DAC_INIT;
      last_reg     <= DAC_RESET;
      peak_reg     <= DAC_RESET;
    end else if (!live) begin
      tick_cnt_reg <= '0;
      deb_cnt_reg  <= '0;
      dac_code     <= DAC_INIT;
      last_reg     <= DAC_RESET;
      peak_reg     <= DAC_RESET;
    end else begin
      tick_cnt_reg <= (!in_event || tick) ? 7'h00 : 7'(tick_cnt_reg + 7'h01);
      // the debounce counter saturates; it restarts once the request drops
      deb_cnt_reg  <= !ovp_req ? 16'h0000 : deb_done ? deb_cnt_reg : 16'(deb_cnt_reg + 16'h0001);
      dac_code     <= dac_next;
      if (in_event && !next_event) last_reg <= dac_code;
      if (!in_event && next_event) peak_reg <= dac_code;
      else if (in_event && dac_next > peak_reg) peak_reg <= dac_next;
    end
  end

  sequence s_flash_end;
    (state_reg == ST_FLASH) && live && !go_down && !any_flash;
  endsequence

  sequence s_wake;
    ((state_reg == ST_SHUTDOWN) && !live) ##1 live;
  endsequence

  property p_shutdown_quiet;
    @(posedge ref_clk) disable iff (!rstn)
    (state_reg == ST_SHUTDOWN) |-> (!boost_en && reg_en == 2'h0);
  endproperty
  a_shutdown_quiet: assert property (p_shutdown_quiet) else $error("output on in shutdown");

  property p_uvlo_reset;
    @(posedge ref_clk) disable iff (!rstn)
    !live |=> (state_reg == ST_SHUTDOWN) && (ctrl_reg == CTRL_RESET);
  endproperty
  a_uvlo_reset: assert property (p_uvlo_reset) else $error("supply low did not reset");

  property p_wake;
    @(posedge ref_clk) disable iff (!rstn)
    s_wake |=> (state_reg == ST_STANDBY);
  endproperty
  a_wake: assert property (p_wake) else $error("no standby after supply good");

  property p_main_uvlo;
    @(posedge ref_clk) disable iff (!rstn)
    (live && state_reg != ST_SHUTDOWN && !ps.main_ok) |=> (state_reg == ST_STANDBY);
  endproperty
  a_main_uvlo: assert property (p_main_uvlo) else $error("main input low not standby");

  property p_active_off;
    @(posedge ref_clk) disable iff (!rstn)
    (state_reg == ST_ACTIVE) |-> (reg_en == 2'h0) && boost_en && (boost_mode == mode_f);
  endproperty
  a_active_off: assert property (p_active_off) else $error("active outputs wrong");

  property p_one_step;
    @(posedge ref_clk) disable iff (!rstn || !live)
    (live && $past(live) && $changed(dac_code)) |->
      (dac_code == 9'($past(dac_code) + 9'h001)) || (dac_code == 9'($past(dac_code) - 9'h001));
  endproperty
  a_one_step: assert property (p_one_step) else $error("DAC moved more than one step");

  property p_min_duty_up;
    @(posedge ref_clk) disable iff (!rstn)
    (live && tick && ps.min_duty) |=> (dac_code >= $past(dac_code));
  endproperty
  a_min_duty_up: assert property (p_min_duty_up) else $error("step down at min duty");

  property p_ilim_down;
    @(posedge ref_clk) disable iff (!rstn)
    (live && tick && ps.ilim) |=> (dac_code <= $past(dac_code));
  endproperty
  a_ilim_down: assert property (p_ilim_down) else $error("step up at current limit");

  property p_ovp_hold;
    @(posedge ref_clk) disable iff (!rstn)
    (live && tick && at_lim && want_up) |=> (dac_code == $past(dac_code));
  endproperty
  a_ovp_hold: assert property (p_ovp_hold) else $error("DAC passed overvoltage limit");

  property p_last_capture;
    @(posedge ref_clk) disable iff (!rstn)
    (live && in_event && !next_event) |=> (last_reg == $past(dac_code)) && (reg_en == 2'h0);
  endproperty
  a_last_capture: assert property (p_last_capture) else $error("last output not captured");

  property p_flash_end;
    @(posedge ref_clk) disable iff (!rstn)
    s_flash_end |=> (state_reg == ($past(any_torch) ? ST_TORCH : ST_ACTIVE));
  endproperty
  a_flash_end: assert property (p_flash_end) else $error("wrong state after flash");

  property p_duty_range;
    @(posedge ref_clk) disable iff (!rstn)
    ##1 (duty_cmd >= DUTY_MIN) && (duty_cmd <= DUTY_MAX);
  endproperty
  a_duty_range: assert property (p_duty_range) else $error("duty out of range");

  property p_fault_off;
    @(posedge ref_clk) disable iff (!rstn)
    (live && ovp_fault) |=> (reg_en == 2'h0) && !boost_en
                            && (state_reg == ST_STANDBY || state_reg == ST_SHUTDOWN);
  endproperty
  a_fault_off: assert property (p_fault_off) else $error("fault did not disable outputs");

  property p_skip;
    @(posedge ref_clk) disable iff (!rstn)
    skip_cycle |-> skip_en && boost_en && $past(ps.vout_high);
  endproperty
  a_skip: assert property (p_skip) else $error("skip without option");

  property p_headroom;
    @(posedge ref_clk) disable iff (!rstn)
    headroom_sel == ctrl_reg[CTRL_HR_LO +: 2];
  endproperty
  a_headroom: assert property (p_headroom) else $error("headroom code not from register");

  property p_flash_use;
    @(posedge ref_clk) disable iff (!rstn)
    (reg_flash != 2'h0) |-> (state_reg == ST_FLASH) && ((reg_flash & ~reg_en) == 2'h0);
  endproperty
  a_flash_use: assert property (p_flash_use) else $error("flash settings outside flash");

  property p_standby_gate;
    @(posedge ref_clk) disable iff (!rstn)
    (state_reg == ST_STANDBY && (!ps.main_ok || ovp_fault)) |=> (state_reg != ST_ACTIVE);
  endproperty
  a_standby_gate: assert property (p_standby_gate) else $error("active entered while blocked");

  property p_step_rate;
    @(posedge ref_clk) disable iff (!rstn || !live)
    (live && $past(live) && $changed(dac_code)) |-> $past(tick);
  endproperty
  a_step_rate: assert property (p_step_rate) else $error("DAC moved without a step tick");

  property p_fault_deb;
    @(posedge ref_clk) disable iff (!rstn)
    $rose(ovp_fault) |-> $past(ovp_req && deb_done);
  endproperty
  a_fault_deb: assert property (p_fault_deb) else $error("fault before debounce expired");

endmodule : fdc_ctrl

// ---- sim/fdc_far_model.sv ----
// far-side model: supply monitors, trigger pins and converter comparators
// assumes the bench drives supply, trigger and converter flags through ctl
module fdc_far_model
  import fdc_pkg::*;
(
  input  wire logic       ref_clk,   // system clock
  input  wire fdc_pins_t  ctl,       // supply, trigger and converter flags
  input  wire logic [8:0] dac_code,  // present DAC code from the device
  input  wire logic [8:0] vf_code,   // code at which headroom just meets target
  output      fdc_pins_t  pins       // levels seen by the device
);
  timeunit 1ns;
  timeprecision 1ns;

  fdc_pins_t pins_next;

  // headroom comparators follow the dac code with one clock of delay, so the
  // loop never sees its own step before the comparator has settled
  always_comb begin
    pins_next         = ctl;
    pins_next.hr_low  = dac_code < vf_code;
    pins_next.hr_high = dac_code > vf_code;
  end

  always_ff @(posedge ref_clk) begin
    pins <= pins_next;
  end
endmodule : fdc_far_model

// ---- sim/test_fdc_ctrl.sv ----
// self-checking bench for the flash driver mode controller and adaptive loop
// assumes the far-side model drives all pin and comparator levels
module test_fdc_ctrl
  import fdc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int DEB = 20;  // short debounce keeps the fault run brief

  logic         ref_clk;
  logic         rstn;
  fdc_bus_req_t bus_req;
  logic [31:0]  rdata;
  fdc_pins_t    pins;
  fdc_pins_t    ctl;
  logic [8:0]   vf;
  logic [5:0]   duty_req;
  logic         boost_en;
  logic [1:0]   boost_mode;
  logic [1:0]   reg_en;
  logic [1:0]   reg_flash;
  logic [8:0]   dac_code;
  logic [1:0]   headroom_sel;
  logic         skip_cycle;
  logic [5:0]   duty_cmd;
  logic         ovp_fault;
  logic [31:0]  d;
  int           miscompares;
  int           samples_checked;
  int           n;
  // [8] skip [7] fault [6] enable [5:4] mode [3:2] regulators [1:0] flash use
  wire  [31:0]  outs = {23'h0, skip_cycle, ovp_fault, boost_en, boost_mode, reg_en, reg_flash};

  fdc_ctrl #(.DEB_CYC(DEB)) dut_u (.ref_clk(ref_clk), .rstn(rstn), .bus_req(bus_req), .rdata(rdata),
    .pins(pins), .duty_req(duty_req), .boost_en(boost_en), .boost_mode(boost_mode), .reg_en(reg_en),
    .reg_flash(reg_flash), .dac_code(dac_code), .headroom_sel(headroom_sel), .skip_cycle(skip_cycle),
    .duty_cmd(duty_cmd), .ovp_fault(ovp_fault));

  fdc_far_model far_u (.ref_clk(ref_clk), .ctl(ctl), .dac_code(dac_code), .vf_code(vf), .pins(pins));

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic tmo;
    miscompares++;
    $display("wrong value at %0t: seen %h expected %h", $time, 32'h0, 32'h1);
    test_done();
  endtask : tmo

  task automatic cyc(input int c);
    repeat (c) @(posedge ref_clk);
  endtask : cyc

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    bus_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    bus_req.wr <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe, so sample mid-cycle
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge ref_clk);
    bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    bus_req.rd <= 1'b0;
    @(negedge ref_clk);
    v = rdata;
  endtask : rd

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    rd(a, d);
    chk(d, exp);
  endtask : rdc

  task automatic wait_st(input logic [2:0] s);
    int i;
    for (i = 0; i < 40; i++) begin
      rd(ADDR_STATUS, d);
      if (d[2:0] === s) break;
    end
    if (i == 40) tmo();
    chk(32'(d[2:0]), 32'(s));
  endtask : wait_st

  task automatic wait_dac(input logic [8:0] v);
    int i;
    for (i = 0; i < 2000 && dac_code !== v; i++) @(negedge ref_clk);
    if (i == 2000) tmo();
  endtask : wait_dac

  initial begin
    rstn = 1'b0;
    bus_req = '0;
    ctl = '0;
    vf = 9'h000;
    duty_req = 6'h0a;
    miscompares = 0;
    samples_checked = 0;
    cyc(10);
    rstn <= 1'b1;
    cyc(8);
    chk(outs, 32'h0);
    chk(32'(dac_code), 32'(DAC_RESET));
    rdc(ADDR_OVP_LIM, 32'h0);
    ctl.supply_ok <= 1'b1;
    wait_st(ST_STANDBY);
    rdc(ADDR_OVP_LIM, 32'h1ff);
    rdc(8'h3c, 32'h0);
    wr(ADDR_CTRL, 32'h001);
    cyc(8);
    rdc(ADDR_STATUS, 32'h1);
    ctl.main_ok <= 1'b1;
    wait_st(ST_ACTIVE);
    chk(outs, 32'h050);
    for (int m = 1; m < 4; m++) begin
      wr(ADDR_CTRL, 32'(m));
      cyc(3);
      chk(32'(boost_mode), 32'(m));
    end
    wr(ADDR_CTRL, 32'h000);
    wait_st(ST_STANDBY);
    wr(ADDR_CTRL, 32'h001);
    wait_st(ST_ACTIVE);
    ctl.main_ok <= 1'b0;
    wait_st(ST_STANDBY);
    ctl.main_ok <= 1'b1;
    wait_st(ST_ACTIVE);
    cyc(1);
    duty_req <= 6'h00;
    cyc(3);
    chk(32'(duty_cmd), 32'h01);
    duty_req <= 6'h3f;
    cyc(3);
    chk(32'(duty_cmd), 32'h18);
    duty_req <= 6'h0a;
    wr(ADDR_CTRL, 32'h101);
    ctl.vout_high <= 1'b1;
    cyc(8);
    chk(32'(skip_cycle), 32'h1);
    wr(ADDR_CTRL, 32'h001);
    cyc(3);
    chk(32'(skip_cycle), 32'h0);
    // gated triggers: the register request alone must not start an event
    wr(ADDR_CTRL, 32'h045);
    cyc(8);
    rdc(ADDR_STATUS, 32'h2);
    ctl.torch_pin <= 1'b1;
    wait_st(ST_TORCH);
    ctl.torch_pin <= 1'b0;
    wait_st(ST_ACTIVE);
    wr(ADDR_CTRL, 32'h091);
    cyc(8);
    rdc(ADDR_STATUS, 32'h2);
    ctl.strobe_trigger <= 1'b1;
    wait_st(ST_FLASH);
    ctl.strobe_trigger <= 1'b0;
    wait_st(ST_ACTIVE);
    vf <= 9'h003;
    wr(ADDR_CTRL, 32'h405);
    wait_st(ST_TORCH);
    chk(outs, 32'h054);
    chk(32'(headroom_sel), 32'h2);
    wait_dac(9'h001);
    for (n = 0; n < 200 && dac_code !== 9'h002; n++) @(negedge ref_clk);
    chk(32'(n), 32'(STEP_NORM_CYC));
    wait_dac(9'h003);
    cyc(200);
    chk(32'(dac_code), 32'h3);
    ctl.min_duty <= 1'b1;
    vf <= 9'h001;
    cyc(200);
    chk(32'(dac_code), 32'h3);
    ctl.soft_start <= 1'b1;
    ctl.min_duty <= 1'b0;
    wait_dac(9'h002);
    for (n = 0; n < 200 && dac_code !== 9'h001; n++) @(negedge ref_clk);
    chk(32'(n), 32'(STEP_SS_CYC));
    rdc(ADDR_PEAK_OUT, 32'h3);
    ctl.ilim <= 1'b1;
    vf <= 9'h006;
    cyc(100);
    chk(32'(dac_code), 32'h1);
    ctl.ilim <= 1'b0;
    wr(ADDR_CTRL, 32'h415);
    wait_st(ST_FLASH);
    chk(outs, 32'h055);
    wr(ADDR_CTRL, 32'h405);
    wait_st(ST_TORCH);
    vf <= 9'h004;
    wait_dac(9'h004);
    wr(ADDR_CTRL, 32'h001);
    wait_st(ST_ACTIVE);
    rdc(ADDR_LAST_OUT, 32'h4);
    wr(ADDR_OVP_LIM, 32'h006);
    vf <= 9'h014;
    wr(ADDR_CTRL, 32'h405);
    wait_dac(9'h006);
    cyc(8);
    chk(32'({ovp_fault, dac_code}), 32'h006);
    for (n = 0; n < 100 && ovp_fault !== 1'b1; n++) @(negedge ref_clk);
    // the state leaves the event one edge after the fault flag rises
    repeat (2) @(negedge ref_clk);
    chk(32'({ovp_fault, boost_en, reg_en}), 32'h8);
    rdc(ADDR_STATUS, 32'h9);
    wr(ADDR_CTRL, 32'h000);
    wr(ADDR_STATUS, 32'h8);
    rdc(ADDR_STATUS, 32'h1);
    ctl.supply_ok <= 1'b0;
    cyc(8);
    chk(outs, 32'h0);
    ctl.supply_ok <= 1'b1;
    wait_st(ST_STANDBY);
    rdc(ADDR_OVP_LIM, 32'h1ff);
    test_done();
  end
endmodule : test_fdc_ctrl
